// File: dcf_pkg.sv
// Constants shared by the dual-clock FIFO flag block
package dcf_pkg;
  // ==========================================
  // Register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  // ==========================================
  // Field positions
  localparam int CTRL_FULL_ALT = 0;
  localparam int CTRL_EMPTY_ALT = 1;
  localparam int ST_FULL = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_DIR = 2;
  localparam int ST_INIT = 3;
  localparam int EV_FULL = 0;
  localparam int EV_EMPTY = 1;
  localparam int EV_OVERFLOW = 2;
  localparam int EV_UNDERFLOW = 3;
  localparam int NUM_EV = 4;
  // ==========================================
  // Reset values, synchroniser stage count and quadrant bits
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  localparam int SYNC_STAGES = 3;
  localparam int QUAD_BITS = 2;
endpackage : dcf_pkg

// File: dcf_fifo.sv
// Dual-clock FIFO with quadrant direction detector and stretched flags
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module dcf_fifo #(
  parameter int DEPTH = 16,
  parameter int WIDTH = (DEPTH == 16) ? 16 : 8
)(
  // Clock, reset, enable
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  // Writer side
  input wire logic WR_CLK,
  input wire logic WR_EN,
  input wire logic [WIDTH-1:0] WR_DATA,
  output logic FULL,
  // Reader side
  input wire logic RD_CLK,
  input wire logic RD_EN,
  output logic [WIDTH-1:0] RD_DATA,
  output logic EMPTY,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Interrupt
  output logic IRQ
);
  // ==========================================
  // Geometry
  localparam int AW = $clog2(DEPTH);
  localparam int LW = AW - dcf_pkg::QUAD_BITS;
  localparam int NBANK = (DEPTH > 16) ? DEPTH / 16 : 1;
  localparam int BW = (NBANK > 1) ? $clog2(NBANK) : 1;
  localparam int NS = dcf_pkg::SYNC_STAGES;
  localparam int NE = dcf_pkg::NUM_EV;

  typedef struct packed {
    logic [NS-1:0] wclk_s;
    logic [NS-1:0] wen_s;
    logic [NS-1:0][WIDTH-1:0] wdat_s;
    logic [NS-1:0] rclk_s;
    logic [NS-1:0] ren_s;
    logic wclk_lvl;
    logic rclk_lvl;
    logic [LW-1:0] wlo;
    logic [1:0] wquad;
    logic [LW-1:0] rlo;
    logic [1:0] rquad;
    logic dir;
    logic init;
    logic full;
    logic empty;
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd_data;
    logic [1:0] ctrl;
    logic [NE-1:0] istat;
    logic [NE-1:0] imask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } dcf_state_t;

  dcf_state_t cur_ff;
  dcf_state_t nxt_ff;

  // ==========================================
  // Counter steps
  function automatic logic [1:0] gray_step(input logic [1:0] g);
    gray_step = {g[0], ~g[1]};
  endfunction : gray_step

  // Low part: Gray for depth 16, zero-inserting shift counter otherwise
  function automatic logic [LW-1:0] low_step(input logic [LW-1:0] s);
    logic fb;
    fb = 1'b0;
    if (LW == 2)
      low_step = LW'(gray_step(2'(s)));
    else
    begin
      fb = s[LW-1] ^ s[LW-3+1] ^ (s[LW-2:0] == '0);
      low_step = {s[LW-2:0], fb};
    end
  endfunction : low_step

  // Last low state before wrap: a one on top, zeros below
  function automatic logic low_last(input logic [LW-1:0] s);
    low_last = (s == {1'b1, {(LW-1){1'b0}}});
  endfunction : low_last

  // Bank number from quadrant: 1-of-2 uses the top Gray bit
  function automatic logic [BW-1:0] bank_of(input logic [1:0] q);
    if (NBANK == 4)
      bank_of = BW'(q);
    else if (NBANK == 2)
      bank_of = BW'(q[1]);
    else
      bank_of = '0;
  endfunction : bank_of

  // ==========================================
  // Next state
  logic wr_rise;
  logic rd_rise;
  logic rd_fall;
  logic wr_req;
  logic rd_req;
  logic do_wr;
  logic do_rd;
  logic same_addr;
  logic raw_full;
  logic raw_empty;
  logic dir_set;
  logic dir_rst;
  logic [NBANK-1:0] bank_we;
  logic [NBANK-1:0] bank_oe;
  logic [AW-1:0] waddr;
  logic [AW-1:0] raddr;
  logic [WIDTH-1:0] bus_word;
  logic [NE-1:0] ev;
  logic acc;
  logic [31:0] rword;
  logic hit;

  always_comb
  begin
    nxt_ff = cur_ff;
    wr_rise = 1'b0;
    rd_rise = 1'b0;
    rd_fall = 1'b0;
    ev = '0;
    rword = '0;
    hit = 1'b1;
    bank_we = '0;
    bank_oe = '0;
    bus_word = '0;
    // Pin synchronisers; first stage feeds only the second
    nxt_ff.wclk_s = {cur_ff.wclk_s[NS-2:0], WR_CLK};
    nxt_ff.wen_s = {cur_ff.wen_s[NS-2:0], WR_EN};
    nxt_ff.wdat_s = {cur_ff.wdat_s[NS-2:0], WR_DATA};
    nxt_ff.rclk_s = {cur_ff.rclk_s[NS-2:0], RD_CLK};
    nxt_ff.ren_s = {cur_ff.ren_s[NS-2:0], RD_EN};
    // Level changes once stages two and three agree
    if (cur_ff.wclk_s[1] == cur_ff.wclk_s[2])
      nxt_ff.wclk_lvl = cur_ff.wclk_s[2];
    if (cur_ff.rclk_s[1] == cur_ff.rclk_s[2])
      nxt_ff.rclk_lvl = cur_ff.rclk_s[2];
    wr_rise = nxt_ff.wclk_lvl & ~cur_ff.wclk_lvl;
    rd_rise = nxt_ff.rclk_lvl & ~cur_ff.rclk_lvl;
    rd_fall = ~nxt_ff.rclk_lvl & cur_ff.rclk_lvl;

    // Equal addresses split by direction
    waddr = {cur_ff.wquad, cur_ff.wlo};
    raddr = {cur_ff.rquad, cur_ff.rlo};
    same_addr = (waddr == raddr);
    raw_full = same_addr & cur_ff.dir;
    raw_empty = same_addr & ~cur_ff.dir;

    // Writes and reads are qualified by enable on a running clock
    wr_req = wr_rise & cur_ff.wen_s[2];
    rd_req = rd_rise & cur_ff.ren_s[2];
    // Internal guard against misuse
    do_wr = wr_req & ~raw_full;
    do_rd = rd_req & ~raw_empty;
    ev[dcf_pkg::EV_OVERFLOW] = wr_req & raw_full;
    ev[dcf_pkg::EV_UNDERFLOW] = rd_req & raw_empty;

    // Bank write decode gated by write enable
    bank_we[bank_of(cur_ff.wquad)] = do_wr;
    for (int b = 0; b < NBANK; b++)
      if (bank_we[b])
        nxt_ff.mem[waddr] = cur_ff.wdat_s[2];

    // Address counters
    if (do_wr)
    begin
      nxt_ff.wlo = low_step(cur_ff.wlo);
      if (low_last(cur_ff.wlo))
        nxt_ff.wquad = gray_step(cur_ff.wquad);
      nxt_ff.init = 1'b1;
    end
    if (do_rd)
    begin
      nxt_ff.rlo = low_step(cur_ff.rlo);
      if (low_last(cur_ff.rlo))
        nxt_ff.rquad = gray_step(cur_ff.rquad);
    end

    // Read mux: per-bank enables onto shared lines, AND-OR in place of drivers
    bank_oe[bank_of(nxt_ff.rquad)] = 1'b1;
    for (int b = 0; b < NBANK; b++)
      if (bank_oe[b])
        bus_word = bus_word | nxt_ff.mem[{nxt_ff.rquad, nxt_ff.rlo}];
    nxt_ff.rd_data = bus_word;

    // Direction from next quadrants; Gray makes the decode glitch-free
    dir_set = (gray_step(nxt_ff.wquad) == nxt_ff.rquad);
    dir_rst = (gray_step(nxt_ff.rquad) == nxt_ff.wquad);
    // Set/reset hold; untouched in same or opposite quadrants
    if (!nxt_ff.init)
      nxt_ff.dir = 1'b0;
    else if (dir_set)
      nxt_ff.dir = 1'b1;
    else if (dir_rst)
      nxt_ff.dir = 1'b0;

    // Full: rises with the write, falls only when the writer may see it
    if ({nxt_ff.wquad, nxt_ff.wlo} == {nxt_ff.rquad, nxt_ff.rlo} && nxt_ff.dir)
    begin
      if (!cur_ff.full)
        ev[dcf_pkg::EV_FULL] = 1'b1;
      nxt_ff.full = 1'b1;
    end
    else if (cur_ff.ctrl[dcf_pkg::CTRL_FULL_ALT])
    begin
      if (wr_rise)
        nxt_ff.full = 1'b0;
    end
    else if (cur_ff.wclk_lvl)
      nxt_ff.full = 1'b0;

    // Empty: mirror, against the read clock, except that the alternate mode drops it at the read fall
    if ({nxt_ff.wquad, nxt_ff.wlo} == {nxt_ff.rquad, nxt_ff.rlo} && !nxt_ff.dir)
    begin
      if (!cur_ff.empty)
        ev[dcf_pkg::EV_EMPTY] = 1'b1;
      nxt_ff.empty = 1'b1;
    end
    else if (cur_ff.ctrl[dcf_pkg::CTRL_EMPTY_ALT])
    begin
      if (rd_fall)
        nxt_ff.empty = 1'b0;
    end
    else if (cur_ff.rclk_lvl)
      nxt_ff.empty = 1'b0;

    // APB: answer is prepared in setup, ready high through the access cycle
    acc = PSEL & PENABLE & cur_ff.pready;
    nxt_ff.pready = PSEL & ~PENABLE;
    unique case (PADDR)
      dcf_pkg::OFS_CTRL:
        rword = {30'h000_0000, cur_ff.ctrl};
      dcf_pkg::OFS_STATUS:
        rword = {28'h000_0000, cur_ff.init, cur_ff.dir, cur_ff.empty, cur_ff.full};
      dcf_pkg::OFS_IRQ_STAT:
        rword = {28'h000_0000, cur_ff.istat};
      dcf_pkg::OFS_IRQ_MASK:
        rword = {28'h000_0000, cur_ff.imask};
      default:
        hit = 1'b0;
    endcase
    if (PSEL & ~PENABLE)
    begin
      nxt_ff.prdata = PWRITE ? 32'h0000_0000 : rword;
      nxt_ff.pslverr = ~hit;
    end
    else if (acc)
    begin
      nxt_ff.pslverr = 1'b0;
      nxt_ff.prdata = 32'h0000_0000;
    end
    if (acc && PWRITE && hit)
    begin
      if (PADDR == dcf_pkg::OFS_CTRL)
        nxt_ff.ctrl = PWDATA[1:0];
      if (PADDR == dcf_pkg::OFS_IRQ_MASK)
        nxt_ff.imask = PWDATA[NE-1:0];
    end
    // Read clears status; a new event in the same cycle survives
    if (acc && !PWRITE && PADDR == dcf_pkg::OFS_IRQ_STAT)
      nxt_ff.istat = '0;
    nxt_ff.istat = nxt_ff.istat | ev;
    nxt_ff.irq = |(nxt_ff.istat & nxt_ff.imask);

    // Clock enable freezes everything
    if (!CLK_EN)
      nxt_ff = cur_ff;
  end

  // ==========================================
  // State register
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      cur_ff <= '0;
      cur_ff.ctrl <= dcf_pkg::CTRL_RST;
      cur_ff.imask <= dcf_pkg::IRQ_MASK_RST;
      cur_ff.empty <= 1'b1;
    end
    else
      cur_ff <= nxt_ff;
  end

  // ==========================================
  // Outputs
  assign FULL = cur_ff.full;
  assign EMPTY = cur_ff.empty;
  assign RD_DATA = cur_ff.rd_data;
  assign PRDATA = cur_ff.prdata;
  assign PREADY = cur_ff.pready;
  assign PSLVERR = cur_ff.pslverr;
  assign IRQ = cur_ff.irq;
endmodule : dcf_fifo
`default_nettype wire

// File: dcf_fifo_checker.sv
// Port-level assertions for the dual-clock FIFO flag block
`timescale 1ns/100ps
`default_nettype none
module dcf_fifo_checker (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // FIFO pins
  input wire logic WR_CLK,
  input wire logic RD_CLK,
  input wire logic FULL,
  input wire logic EMPTY,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  // ==========================================
  // Mode shadow
  logic [1:0] ctrl_ff;
  logic mapped;
  assign mapped = PADDR[7:4] == 4'h0 && PADDR[1:0] == 2'h0;
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
      ctrl_ff <= dcf_pkg::CTRL_RST;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == dcf_pkg::OFS_CTRL)
      ctrl_ff <= PWDATA[1:0];
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);
  apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  unmapped_err_a: assert property (PSEL && !PENABLE && !mapped |=> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("unmapped not refused");
  flags_apart_a: assert property (!(FULL && EMPTY))
    else $error("full and empty");
  full_rise_a: assert property ($rose(FULL) |-> $past(WR_CLK, 3) && !$past(WR_CLK, 7))
    else $error("full off write edge");
  empty_rise_a: assert property ($rose(EMPTY) |-> $past(RD_CLK, 3) && !$past(RD_CLK, 8))
    else $error("empty off read edge");
  full_drop_a: assert property ($fell(FULL) && !$past(ctrl_ff[0]) |->
    $past(WR_CLK, 2) || $past(WR_CLK, 3) || $past(WR_CLK, 4) || $past(WR_CLK, 5))
    else $error("full dropped in low phase");
  full_sync_a: assert property ($fell(FULL) && $past(ctrl_ff[0]) |-> $past(WR_CLK, 3) && !$past(WR_CLK, 7))
    else $error("full drop off edge");
  empty_drop_a: assert property ($fell(EMPTY) && !$past(ctrl_ff[1]) |->
    $past(RD_CLK, 2) || $past(RD_CLK, 3) || $past(RD_CLK, 4) || $past(RD_CLK, 5))
    else $error("empty dropped in low phase");
  empty_sync_a: assert property ($fell(EMPTY) && $past(ctrl_ff[1]) |-> !$past(RD_CLK, 3) && $past(RD_CLK, 9))
    else $error("empty drop off read fall");
endmodule : dcf_fifo_checker
bind dcf_fifo dcf_fifo_checker i_chk (.REF_CLK(REF_CLK), .RESETN(RESETN), .WR_CLK(WR_CLK), .RD_CLK(RD_CLK),
  .FULL(FULL), .EMPTY(EMPTY), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
`default_nettype wire

// File: dcf_partner.sv
// Writer and reader control logic facing the FIFO
`timescale 1ns/100ps
`default_nettype none
module dcf_partner #(parameter int W = 8) (
  // Control
  input wire logic ref_clk,
  input wire logic go_wr,
  input wire logic go_rd,
  // Writer
  output var logic wr_clk = 1'b0,
  output var logic wr_en = 1'b0,
  output var logic [W-1:0] wr_data = '0,
  output var logic [7:0] wr_cnt = 8'h00,
  input wire logic full,
  // Reader
  output var logic rd_clk = 1'b0,
  output var logic rd_en = 1'b0,
  output var logic rd_stb = 1'b0,
  output var logic [W-1:0] rd_word = '0,
  input wire logic [W-1:0] rd_data,
  input wire logic empty
);
  // Unequal half periods so the clocks drift apart
  int wt = 0;
  int rt = 0;
  always @(posedge ref_clk)
  begin
    wt <= (wt + 1) % 7;
    rt <= (rt + 1) % 8;
    rd_stb <= rt == 7 && !rd_clk && rd_en;
    if (wt == 6)
    begin
      wr_clk <= !wr_clk;
      // Decided at the fall, so the flag has settled
      if (wr_clk)
      begin
        wr_en <= go_wr && !full;
        wr_data <= wr_cnt[W-1:0];
      end
      else if (wr_en)
        wr_cnt <= wr_cnt + 8'h01;
    end
    if (rt == 7)
    begin
      rd_clk <= !rd_clk;
      if (rd_clk)
        rd_en <= go_rd && !empty;
      else if (rd_en)
        rd_word <= rd_data;
    end
  end
endmodule : dcf_partner
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the dual-clock FIFO flag block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, slv, irq, full, empty, wr_clk, wr_en, rd_clk, rd_en, rd_stb;
  logic go_wr = 1'b0;
  logic go_rd = 1'b0;
  logic [7:0] wr_data, rd_data, rd_word, wr_cnt;
  logic [7:0] exp_rd = 8'h00;
  int n_errors = 0;
  int samples_checked = 0;
  always #10 clk = !clk;
  // Depth 32 exercises the two-bank path
  dcf_fifo #(.DEPTH(32)) i_dut (.REF_CLK(clk), .RESETN(resetn), .CLK_EN(1'b1), .WR_CLK(wr_clk), .WR_EN(wr_en),
    .WR_DATA(wr_data), .FULL(full), .RD_CLK(rd_clk), .RD_EN(rd_en), .RD_DATA(rd_data), .EMPTY(empty),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
  dcf_partner #(.W(8)) i_far (.ref_clk(clk), .go_wr(go_wr), .go_rd(go_rd), .wr_clk(wr_clk), .wr_en(wr_en),
    .wr_data(wr_data), .wr_cnt(wr_cnt), .full(full), .rd_clk(rd_clk), .rd_en(rd_en), .rd_stb(rd_stb),
    .rd_word(rd_word), .rd_data(rd_data), .empty(empty));
  // ==========================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    rdata = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic results;
    $display("mismatches %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // ==========================================
  // Read data must come out in write order
  always @(posedge clk)
  begin
    if (rd_stb === 1'b1)
    begin
      chk("rd_data", rd_word, exp_rd);
      exp_rd <= exp_rd + 8'h01;
    end
  end
  initial
  begin
    #400_000;
    n_errors++;
    results();
  end
  // ==========================================
  // Sequence
  initial
  begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("full", full, 32'h0000_0000);
    chk("empty", empty, 32'h0000_0001);
    apb(1'b0, dcf_pkg::OFS_STATUS, 32'h0000_0000);
    chk("status", rdata, 32'h0000_0002);
    apb(1'b0, dcf_pkg::OFS_CTRL, 32'h0000_0000);
    chk("ctrl", rdata, 32'h0000_0000);
    apb(1'b0, dcf_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    chk("mask", rdata, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", rdata, 32'h0000_0000);
    chk("slverr", slv, 32'h0000_0001);
    apb(1'b0, dcf_pkg::OFS_IRQ_STAT, 32'h0000_0000);
    apb(1'b1, dcf_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    go_wr <= 1'b1;
    for (int i = 0; i < 2000 && full !== 1'b1; i++) @(posedge clk);
    repeat (60) @(posedge clk);
    chk("written", wr_cnt, 32'h0000_0020);
    apb(1'b0, dcf_pkg::OFS_STATUS, 32'h0000_0000);
    chk("status", rdata, 32'h0000_000D);
    chk("irq", irq, 32'h0000_0001);
    apb(1'b0, dcf_pkg::OFS_IRQ_STAT, 32'h0000_0000);
    chk("irq_stat", rdata, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk("irq", irq, 32'h0000_0000);
    // Masked event stays sticky but silent
    apb(1'b1, dcf_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    go_wr <= 1'b0;
    go_rd <= 1'b1;
    for (int i = 0; i < 2000 && empty !== 1'b1; i++) @(posedge clk);
    repeat (60) @(posedge clk);
    chk("read", exp_rd, 32'h0000_0020);
    chk("irq", irq, 32'h0000_0000);
    apb(1'b0, dcf_pkg::OFS_IRQ_STAT, 32'h0000_0000);
    chk("irq_stat", rdata, 32'h0000_0002);
    apb(1'b0, dcf_pkg::OFS_STATUS, 32'h0000_0000);
    chk("status", rdata, 32'h0000_000A);
    apb(1'b1, dcf_pkg::OFS_CTRL, 32'h0000_0003);
    apb(1'b0, dcf_pkg::OFS_CTRL, 32'h0000_0000);
    chk("ctrl", rdata, 32'h0000_0003);
    // Writer slightly faster, so full is reached while both run
    go_wr <= 1'b1;
    repeat (6000) @(posedge clk);
    go_wr <= 1'b0;
    for (int i = 0; i < 3000 && empty !== 1'b1; i++) @(posedge clk);
    repeat (60) @(posedge clk);
    chk("drained", exp_rd, wr_cnt);
    results();
  end
endmodule : testbench
`default_nettype wire
